// ===== lowv_map.svh
`ifndef LOWV_MAP_SVH
`define LOWV_MAP_SVH
// ****************************************
// Register addresses
// ****************************************
`define LOWV_CONTROL_ADDR     32'hfffff890
`define RAM_STATUS_ADDR       32'hfffff892
`define EMU_FORCE_ADDR        32'hfffff9fe
`define THRESHOLD_SEL_ADDR    32'hfffff891
`define PROTECT_KEY_ADDR      32'hfffff8fc
// ****************************************
// Field positions
// ****************************************
`define DETECT_ON_BIT         7
`define RESET_MODE_BIT        1
`define BELOW_FLAG_BIT        0
`define THRESHOLD_BIT         0
`define RAM_INVALID_BIT       0
`define EMU_RAM_FORCE_BIT     2
// ****************************************
// Reset values and timing
// ****************************************
`define LOWV_CONTROL_RST      8'h00
`define RAM_STATUS_RST        8'h01
`define EMU_FORCE_RST         8'h00
`define THRESHOLD_RST         8'h00
`define SETTLE_TIME_US        200
`define CLK_MHZ               20
`define SETTLE_CYCLES         (`SETTLE_TIME_US * `CLK_MHZ)
`endif

// ===== lowv_pkg.sv
`default_nettype none
package lowv_pkg;
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
      logic        bit_op;
   } bus_req_t;
   typedef enum logic [1:0] {
      PROT_IDLE  = 2'b00,
      PROT_ARMED = 2'b01
   } prot_state_t;
endpackage
`default_nettype wire

// ===== lowv_ctrl.sv
// Operation
// - Control register changes only through the protected write sequence.
// - Control register byte/bit access; bit 0 ignores writes.
// - Bit 7 enables detection.
// - Bit 1 selects interrupt (0) or internal reset (1).
// - Bit 0 shows supply below level while enabled, else 0.
// - Interrupt output follows the flag when enabled in interrupt mode.
// - Armed reset mode locks the control register until a foreign reset.
// - Armed reset mode locks the threshold register likewise.
// - Threshold bit 0 picks higher level, 1 lower level.
// - Threshold register is byte access, upper bits kept zero.
// - RAM status is protected, bit 0 invalid flag, resets to 1.
// - RAM flag set by retention loss, instruction, watchdog, RAM, clock-monitor resets; the block has no instruction-reset input.
// - RAM flag clears only by protected write of 0.
// - Retention comparator low sets the RAM flag, also at power-up.
// - Reset mode holds internal reset while supply is low.
// - Detector reset sets cause bit 0 of reset cause register.
// - In emulation, force bit sets RAM flag and holds until cleared.
// - While force bit is 1 in emulation mode, software cannot clear the RAM flag.
`include "lowv_map.svh"
`default_nettype none
module lowv_ctrl (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // Register port
   input  wire logic [31:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   // Reset sources and emulation mode
   input  wire logic        foreign_reset_i,
   input  wire logic        watchdog_reset_i,
   input  wire logic        ram_access_reset_i,
   input  wire logic        clk_monitor_reset_i,
   input  wire logic        emu_mode_i,
   // Analog comparators
   input  wire logic        below_level_raw_i,
   input  wire logic        below_retention_raw_i,
   // Outputs to system
   output logic             threshold_bit_o,
   output logic             lowv_irq_o,
   output logic             lowv_reset_out_o,
   output logic             lowv_reset_cause_o
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic [1:0] lvl_sync_q;
   logic [1:0] ret_sync_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lvl_sync_q <= 2'h0;
         ret_sync_q <= 2'h3;
      end else begin
         lvl_sync_q <= {lvl_sync_q[0], below_level_raw_i};
         ret_sync_q <= {ret_sync_q[0], below_retention_raw_i};
      end
   end
   wire logic below_lvl  = lvl_sync_q[1];
   wire logic below_ret  = ret_sync_q[1];
   // ****************************************
   // Protected write sequence
   // ****************************************
   // A write to the key address opens exactly the next write.
   lowv_pkg::prot_state_t prot_q;
   wire logic key_wr  = wr_i && (addr_i == `PROTECT_KEY_ADDR);
   wire logic prot_ok = wr_i && !key_wr && (prot_q == lowv_pkg::PROT_ARMED);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prot_q <= lowv_pkg::PROT_IDLE;
      end else if (key_wr) begin
         prot_q <= lowv_pkg::PROT_ARMED;
      end else if (wr_i) begin
         prot_q <= lowv_pkg::PROT_IDLE;
      end
   end
   // ****************************************
   // Control and threshold registers
   // ****************************************
   logic detect_on_q;
   logic reset_mode_select_q;
   logic threshold_bit_q;
   logic below_level_flag;
   wire logic locked = detect_on_q && reset_mode_select_q;
   wire logic ctl_wr = prot_ok && (addr_i == `LOWV_CONTROL_ADDR);
   wire logic thr_wr = wr_i && (addr_i == `THRESHOLD_SEL_ADDR);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         detect_on_q         <= 1'b0;
         reset_mode_select_q <= 1'b0;
      end else if (foreign_reset_i) begin
         detect_on_q         <= 1'b0;
         reset_mode_select_q <= 1'b0;
      end else if (ctl_wr && !locked) begin
         detect_on_q         <= wdata_i[`DETECT_ON_BIT];
         reset_mode_select_q <= wdata_i[`RESET_MODE_BIT];
         // Bit 0 is not stored: it mirrors the comparator
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         threshold_bit_q <= 1'b0;
      end else if (foreign_reset_i) begin
         threshold_bit_q <= 1'b0;
      end else if (thr_wr && !locked) begin
         threshold_bit_q <= wdata_i[`THRESHOLD_BIT];
      end
   end
   assign below_level_flag = detect_on_q && below_lvl;
   // ****************************************
   // RAM status and emulation force
   // ****************************************
   logic ram_invalid_q;
   logic emu_ram_force_q;
   wire logic emu_force_on = emu_ram_force_q && emu_mode_i;
   wire logic emu_wr = wr_i && emu_mode_i && (addr_i == `EMU_FORCE_ADDR);
   wire logic ram_wr = prot_ok && (addr_i == `RAM_STATUS_ADDR);
   wire logic ram_set = below_ret || emu_force_on || watchdog_reset_i
                        || ram_access_reset_i || clk_monitor_reset_i
                        || (ram_wr && wdata_i[`RAM_INVALID_BIT]);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         emu_ram_force_q <= 1'b0;
      end else if (emu_wr) begin
         emu_ram_force_q <= wdata_i[`EMU_RAM_FORCE_BIT];
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ram_invalid_q <= 1'b1;
      end else if (ram_set) begin
         ram_invalid_q <= 1'b1;
      end else if (ram_wr && !wdata_i[`RAM_INVALID_BIT]) begin
         ram_invalid_q <= 1'b0;
      end
   end
   // ****************************************
   // System outputs
   // ****************************************
   logic irq_q;
   logic rst_q;
   logic cause_q;
   logic thr_out_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_q     <= 1'b0;
         rst_q     <= 1'b0;
         thr_out_q <= 1'b0;
      end else begin
         irq_q     <= below_level_flag && !reset_mode_select_q;
         rst_q     <= below_level_flag && reset_mode_select_q;
         thr_out_q <= threshold_bit_q;
      end
   end
   // Cause is sticky across the detector's own reset; a foreign reset clears it unless rst_q is high in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cause_q <= 1'b0;
      end else if (rst_q) begin
         cause_q <= 1'b1;
      end else if (foreign_reset_i) begin
         cause_q <= 1'b0;
      end
   end
   assign lowv_irq_o         = irq_q;
   assign lowv_reset_out_o   = rst_q;
   assign lowv_reset_cause_o = cause_q;
   assign threshold_bit_o    = thr_out_q;
   // ****************************************
   // Read path
   // ****************************************
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   always_comb begin
      rdata_d = 8'h00;
      unique case (addr_i)
         `LOWV_CONTROL_ADDR:  rdata_d = {detect_on_q, 5'h00, reset_mode_select_q,
                                         below_level_flag};
         `THRESHOLD_SEL_ADDR: rdata_d = {7'h00, threshold_bit_q};
         `RAM_STATUS_ADDR:    rdata_d = {7'h00, ram_invalid_q};
         `EMU_FORCE_ADDR:     rdata_d = {5'h00, emu_force_on, 2'h0};
         default:             rdata_d = 8'h00;
      endcase
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= 8'h00;
      end else if (rd_i) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_o = rdata_q;
   // ****************************************
   // Checks: system outputs
   // ****************************************
   // Outputs lag the flag by one flop, so most checks look one edge later

   irq_follows_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (below_level_flag && !reset_mode_select_q) |=> lowv_irq_o)
      else $error("irq not following flag");

   irq_drops_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !below_level_flag |=> !lowv_irq_o)
      else $error("irq without flag");

   reset_holds_low_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (below_level_flag && reset_mode_select_q) |=> lowv_reset_out_o && !lowv_irq_o)
      else $error("reset not held");

   reset_release_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !below_level_flag |=> !lowv_reset_out_o)
      else $error("reset without flag");

   mode_excl_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !(lowv_irq_o && lowv_reset_out_o))
      else $error("irq and reset together");

   detect_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !detect_on_q |=> !lowv_irq_o && !lowv_reset_out_o)
      else $error("response while detection off");

   cause_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      lowv_reset_out_o |=> lowv_reset_cause_o)
      else $error("cause bit not set");

   cause_sticky_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (lowv_reset_cause_o && !foreign_reset_i) |=> lowv_reset_cause_o)
      else $error("cause bit lost");

   cause_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (foreign_reset_i && !rst_q) |=> !lowv_reset_cause_o)
      else $error("cause bit not cleared");

   thr_out_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> threshold_bit_o == $past(threshold_bit_q))
      else $error("threshold output wrong");

   // ****************************************
   // Checks: control and threshold registers
   // ****************************************
   // The lock is the hazard here: a stray write must never disarm reset mode

   lock_holds_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (locked && !foreign_reset_i) |=> locked)
      else $error("lock released");

   foreign_unlock_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      foreign_reset_i |=> !locked)
      else $error("lock kept after foreign reset");

   thr_locked_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (locked && !foreign_reset_i) |=> $stable(threshold_bit_q))
      else $error("threshold changed while locked");

   thr_foreign_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      foreign_reset_i |=> !threshold_bit_q)
      else $error("threshold kept after foreign reset");

   unprot_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && prot_q == lowv_pkg::PROT_IDLE && !foreign_reset_i) |=>
      $stable(detect_on_q) && $stable(reset_mode_select_q))
      else $error("unprotected write took effect");

   prot_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (ctl_wr && !locked && !foreign_reset_i) |=>
      detect_on_q == $past(wdata_i[`DETECT_ON_BIT])
      && reset_mode_select_q == $past(wdata_i[`RESET_MODE_BIT]))
      else $error("protected write not taken");

   prot_one_shot_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wr_i && !key_wr) |=> prot_q == lowv_pkg::PROT_IDLE)
      else $error("protection stays open");

   flag_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !detect_on_q |-> !below_level_flag)
      else $error("flag set while disabled");

   ctl_bit0_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == `LOWV_CONTROL_ADDR) |=>
      rdata_o[`BELOW_FLAG_BIT] == $past(below_level_flag) && rdata_o[6:2] == 5'h00)
      else $error("control read wrong");

   thr_read_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == `THRESHOLD_SEL_ADDR) |=> rdata_o[7:1] == 7'h00)
      else $error("threshold upper bits set");

   rdata_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read");

   // ****************************************
   // Checks: RAM flag and emulation force
   // ****************************************
   // Set must win over clear, or a brown-out during the clear would be missed

   ram_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      below_ret |=> ram_invalid_q)
      else $error("ram flag not set");

   ram_sources_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (watchdog_reset_i || ram_access_reset_i || clk_monitor_reset_i) |=> ram_invalid_q)
      else $error("ram flag missed a reset source");

   ram_read_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == `RAM_STATUS_ADDR) |=> rdata_o == {7'h00, $past(ram_invalid_q)})
      else $error("ram status read wrong");

   force_blocks_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      emu_force_on |=> ram_invalid_q)
      else $error("ram flag cleared under force");

   force_holds_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (emu_ram_force_q && !emu_wr) |=> emu_ram_force_q)
      else $error("force bit cleared by itself");

   emu_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == `EMU_FORCE_ADDR && !emu_mode_i) |=> rdata_o == 8'h00)
      else $error("force bit visible outside emulation");

   ram_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!ram_invalid_q && $past(ram_invalid_q)) |-> $past(ram_wr))
      else $error("ram flag cleared without protected write");
endmodule
`default_nettype wire

// ===== supply_model.sv
`default_nettype none
module supply_model #(
   parameter logic [15:0] HIGH_MV   = 16'h1130,
   parameter logic [15:0] LOW_MV    = 16'h1068,
   parameter logic [15:0] RETAIN_MV = 16'h07d0
) (
   // Supply and level choice
   input  wire logic [15:0] supply_mv_i,
   input  wire logic        threshold_bit_i,
   // Comparator levels, high while the supply is under the level
   output logic             below_level_o,
   output logic             below_retention_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Comparators
   // ****************************************
   // Always powered, so the detect enable is applied by the block, not here
   assign below_level_o     = supply_mv_i < (threshold_bit_i ? LOW_MV : HIGH_MV);
   assign below_retention_o = supply_mv_i < RETAIN_MV;
endmodule
`default_nettype wire

// ===== tb_top.sv
`include "lowv_map.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, arst_n_i, wr_i, rd_i, foreign_reset_i, emu_mode_i;
   logic [31:0] addr_i;
   logic [7:0]  wdata_i, rdata_o;
   logic [2:0]  src_q;
   logic [15:0] supply_mv;
   logic        below_level_raw_i, below_retention_raw_i;
   logic        threshold_bit_o, lowv_irq_o, lowv_reset_out_o, lowv_reset_cause_o;
   int          errors, checks, cycles;
   lowv_ctrl lowv_ctrl_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .foreign_reset_i(foreign_reset_i), .watchdog_reset_i(src_q[0]),
      .ram_access_reset_i(src_q[1]), .clk_monitor_reset_i(src_q[2]),
      .emu_mode_i(emu_mode_i), .below_level_raw_i(below_level_raw_i),
      .below_retention_raw_i(below_retention_raw_i), .threshold_bit_o(threshold_bit_o),
      .lowv_irq_o(lowv_irq_o), .lowv_reset_out_o(lowv_reset_out_o),
      .lowv_reset_cause_o(lowv_reset_cause_o));
   supply_model supply_model_i (.supply_mv_i(supply_mv), .threshold_bit_i(threshold_bit_o),
      .below_level_o(below_level_raw_i), .below_retention_o(below_retention_raw_i));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   // Key write first; the idle cycle between the two writes does not disarm
   task automatic pwr(input logic [31:0] a, input logic [7:0] d);
      wr(`PROTECT_KEY_ADDR, 8'h00);
      wr(a, d);
   endtask
   task automatic rdc(input string name, input logic [31:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 chk(name, rdata_o, exp);
   endtask
   // Two synchroniser stages and the output flop, plus margin
   task automatic wait_sync;
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      rdc("control", `LOWV_CONTROL_ADDR, 8'h00);
      rdc("ram", `RAM_STATUS_ADDR, 8'h01);
      rdc("emu", `EMU_FORCE_ADDR, 8'h00);
      rdc("threshold", `THRESHOLD_SEL_ADDR, 8'h00);
      rdc("unmapped", 32'hfffff8a0, 8'h00);
      wr(`LOWV_CONTROL_ADDR, 8'h80);
      rdc("unprotected", `LOWV_CONTROL_ADDR, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_irq;
      pwr(`LOWV_CONTROL_ADDR, 8'h81);
      repeat (`SETTLE_CYCLES) @(posedge clk_i);
      rdc("bit0 ro", `LOWV_CONTROL_ADDR, 8'h80);
      supply_mv = 16'h10cc;
      wait_sync;
      chk("irq", {7'h00, lowv_irq_o}, 8'h01);
      chk("no reset", {7'h00, lowv_reset_out_o}, 8'h00);
      rdc("flag", `LOWV_CONTROL_ADDR, 8'h81);
      pwr(`THRESHOLD_SEL_ADDR, 8'h01);
      wait_sync;
      chk("lower level", {7'h00, threshold_bit_o, lowv_irq_o}, 8'h02);
      pwr(`THRESHOLD_SEL_ADDR, 8'h00);
      wait_sync;
      pwr(`LOWV_CONTROL_ADDR, 8'h00);
      wait_sync;
      chk("irq off", {7'h00, lowv_irq_o}, 8'h00);
      rdc("flag off", `LOWV_CONTROL_ADDR, 8'h00);
      $display("test interrupt done");
   endtask
   task automatic t_resetmode;
      supply_mv = 16'h1388;
      pwr(`THRESHOLD_SEL_ADDR, 8'h00);
      pwr(`LOWV_CONTROL_ADDR, 8'h80);
      repeat (`SETTLE_CYCLES) @(posedge clk_i);
      rdc("above", `LOWV_CONTROL_ADDR, 8'h80);
      pwr(`LOWV_CONTROL_ADDR, 8'h82);
      supply_mv = 16'h0fa0;
      wait_sync;
      chk("reset out", {6'h00, lowv_reset_out_o, lowv_irq_o}, 8'h02);
      chk("cause", {7'h00, lowv_reset_cause_o}, 8'h01);
      pwr(`LOWV_CONTROL_ADDR, 8'h00);
      pwr(`THRESHOLD_SEL_ADDR, 8'h01);
      rdc("ctrl locked", `LOWV_CONTROL_ADDR, 8'h83);
      rdc("thr locked", `THRESHOLD_SEL_ADDR, 8'h00);
      chk("reset held", {7'h00, lowv_reset_out_o}, 8'h01);
      supply_mv = 16'h1388;
      wait_sync;
      chk("reset gone", {6'h00, lowv_reset_out_o, lowv_reset_cause_o}, 8'h01);
      @(posedge clk_i);
      foreign_reset_i <= 1'b1;
      @(posedge clk_i);
      foreign_reset_i <= 1'b0;
      wait_sync;
      chk("cause clear", {7'h00, lowv_reset_cause_o}, 8'h00);
      rdc("unlocked", `LOWV_CONTROL_ADDR, 8'h00);
      $display("test reset mode done");
   endtask
   task automatic t_ram;
      wr(`RAM_STATUS_ADDR, 8'h00);
      rdc("ram unprot", `RAM_STATUS_ADDR, 8'h01);
      pwr(`RAM_STATUS_ADDR, 8'h00);
      rdc("ram clear", `RAM_STATUS_ADDR, 8'h00);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         src_q <= 3'h1 << i;
         @(posedge clk_i);
         src_q <= 3'h0;
         rdc("ram source", `RAM_STATUS_ADDR, 8'h01);
         pwr(`RAM_STATUS_ADDR, 8'h00);
      end
      supply_mv = 16'h05dc;
      wait_sync;
      supply_mv = 16'h1388;
      wait_sync;
      rdc("retention", `RAM_STATUS_ADDR, 8'h01);
      pwr(`RAM_STATUS_ADDR, 8'h00);
      wr(`EMU_FORCE_ADDR, 8'h04);
      rdc("emu inert", `EMU_FORCE_ADDR, 8'h00);
      rdc("ram kept", `RAM_STATUS_ADDR, 8'h00);
      emu_mode_i <= 1'b1;
      wr(`EMU_FORCE_ADDR, 8'h04);
      rdc("emu set", `EMU_FORCE_ADDR, 8'h04);
      pwr(`RAM_STATUS_ADDR, 8'h00);
      rdc("forced", `RAM_STATUS_ADDR, 8'h01);
      wr(`EMU_FORCE_ADDR, 8'h00);
      pwr(`RAM_STATUS_ADDR, 8'h00);
      rdc("released", `RAM_STATUS_ADDR, 8'h00);
      $display("test ram flag done");
   endtask
   // ****************************************
   // Run control
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         results();
      end
   end
   initial begin
      {arst_n_i, wr_i, rd_i, foreign_reset_i, emu_mode_i} = 5'h00;
      addr_i    = 32'h00000000;
      wdata_i   = 8'h00;
      src_q     = 3'h0;
      supply_mv = 16'h1388;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_irq();
      t_resetmode();
      t_ram();
      results();
   end
endmodule
`default_nettype wire
